//--- verilog/usdp_pkg.sv
// constants, types and state codes of the shadow data port
package usdp_pkg;

    // ---------------------------------------------------------------
    // register map
    // ---------------------------------------------------------------
    localparam logic [31:0] SHADOW_13_ADDR  = 32'h5000_1164;
    localparam logic [31:0] SHADOW_14_ADDR  = 32'h5000_1168;
    localparam int          ALIAS_WORDS     = 16;
    localparam logic [31:0] ALIAS_BASE      = SHADOW_13_ADDR - 32'h0000_0034;
    localparam logic [31:0] ALIAS_LAST      = ALIAS_BASE + 32'h0000_003C;
    localparam logic [31:0] CTRL_ADDR       = 32'h5000_1100;
    localparam logic [31:0] LSR_ADDR        = 32'h5000_1104;
    localparam logic [31:0] INT_STAT_ADDR   = 32'h5000_1108;
    localparam logic [31:0] INT_MASK_ADDR   = 32'h5000_110C;

    // ---------------------------------------------------------------
    // field positions and reset values
    // ---------------------------------------------------------------
    localparam int          CTRL_FIFO_EN_BIT = 0;
    localparam int          CTRL_IR_MODE_BIT = 1;
    localparam int          CTRL_W           = 2;
    localparam int          LSR_DR_BIT       = 0;
    localparam int          LSR_OE_BIT       = 1;
    localparam int          LSR_TX_HOLDING_EMPTY_FLAG_BIT     = 5;
    localparam int          INT_RX_BIT       = 0;
    localparam int          INT_OE_BIT       = 1;
    localparam int          INT_TX_HOLDING_EMPTY_FLAG_BIT     = 2;
    localparam int          INT_W            = 3;
    localparam logic [1:0]  CTRL_RESET       = 2'h0;
    localparam logic [2:0]  INT_MASK_RESET   = 3'h0;
    localparam logic [2:0]  INT_STAT_RESET   = 3'h0;
    localparam logic [1:0]  HTRANS_NONSEQ    = 2'h2;

    // ---------------------------------------------------------------
    // sizes and timing
    // ---------------------------------------------------------------
    localparam int          FIFO_DEPTH_DEFAULT = 16;
    localparam int          CLK_FREQ_HZ        = 100_000_000;
    localparam int          BAUD_DEFAULT       = 115_200;
    localparam int          BIT_CYCLES_DEFAULT = CLK_FREQ_HZ / BAUD_DEFAULT;

    // ---------------------------------------------------------------
    // types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } usdp_rx_state_t;

    typedef enum logic [1:0] {
        TX_IDLE,
        TX_START,
        TX_DATA,
        TX_STOP
    } usdp_tx_state_t;

    typedef struct packed {
        logic        pending;
        logic        write;
        logic [31:0] addr;
    } usdp_ahb_req_t;

endpackage

//--- verilog/usdp_top.sv
// shadow receive/transmit data port with ahb-lite register slave
//
// What this block does
// - Sixteen word addresses form one alias so a master can burst to it.
// - Reading the alias returns the received byte in bits 7:0.
// - Alias read data is only meaningful while the data-ready flag is set.
// - Without fifos a new byte overwrites an unread one and flags overrun.
// - With fifos a read of the alias returns the receive fifo head.
// - A byte arriving at a full receive fifo is dropped with overrun unless a read pops the head in the same cycle.
// - Writing the alias sends a byte on the serial or ir output.
// - Without fifos one write clears the holding-empty flag.
// - Without fifos further writes overwrite the pending holding byte.
// - With fifos up to the fifo depth of bytes are accepted.
// - A write while the transmit fifo is full is discarded unless the transmitter takes a byte in the same cycle.
`timescale 1ns/1ps
module usdp_top
    import usdp_pkg::*;
#(
    parameter int DEPTH      = FIFO_DEPTH_DEFAULT,
    parameter int BIT_CYCLES = BIT_CYCLES_DEFAULT
) (
    input  wire logic        clk_sys,
    input  wire logic        srst,
    input  wire logic        hsel,
    input  wire logic [31:0] haddr,
    input  wire logic [1:0]  htrans,
    input  wire logic        hwrite,
    input  wire logic [2:0]  hsize,
    input  wire logic [31:0] hwdata,
    input  wire logic        hready,
    output logic      [31:0] hrdata,
    output logic             hreadyout,
    output logic             hresp,
    output logic             irq,
    input  wire logic        sin,
    input  wire logic        sir_in,
    output logic             sout,
    output logic             sir_out_n
);

    // ---------------------------------------------------------------
    // sizes
    // ---------------------------------------------------------------
    localparam int PW   = (DEPTH > 1) ? $clog2(DEPTH) : 1;
    localparam int CW   = $clog2(DEPTH + 1);
    localparam int TW   = $clog2(BIT_CYCLES + 1);
    localparam logic [CW-1:0] CNT_FULL  = CW'(DEPTH);
    localparam logic [PW-1:0] PTR_LAST  = PW'(DEPTH - 1);
    localparam logic [TW-1:0] TIME_FULL = TW'(BIT_CYCLES - 1);
    localparam logic [TW-1:0] TIME_HALF = TW'(BIT_CYCLES / 2);

    typedef struct packed {
        usdp_ahb_req_t           req;
        logic [31:0]             hrdata;
        logic                    hreadyout;
        logic                    irq;
        logic [CTRL_W-1:0]       ctrl;
        logic [INT_W-1:0]        int_stat;
        logic [INT_W-1:0]        int_mask;
        logic                    overrun;
        logic [7:0]              rx_hold;
        logic                    rx_hold_valid;
        logic [DEPTH-1:0][7:0]   rx_mem;
        logic [PW-1:0]           rx_rd;
        logic [PW-1:0]           rx_wr;
        logic [CW-1:0]           rx_cnt;
        logic [7:0]              transmit_holding;
        logic                    tx_holding_empty_flag;
        logic [DEPTH-1:0][7:0]   tx_mem;
        logic [PW-1:0]           tx_rd;
        logic [PW-1:0]           tx_wr;
        logic [CW-1:0]           tx_cnt;
        logic                    sin_meta;
        logic                    sin_sync;
        logic                    sir_meta;
        logic                    sir_sync;
        usdp_rx_state_t          rx_state;
        logic [TW-1:0]           rx_timer;
        logic [2:0]              rx_bit;
        logic [7:0]              rx_shift;
        usdp_tx_state_t          tx_state;
        logic [TW-1:0]           tx_timer;
        logic [2:0]              tx_bit;
        logic [7:0]              tx_shift;
        logic                    tx_line;
        logic                    sout;
        logic                    sir_out_n;
    } usdp_state_t;

    usdp_state_t cur;
    usdp_state_t next_cur;

    function automatic logic [PW-1:0] adv(input logic [PW-1:0] p);
        return (p == PTR_LAST) ? '0 : PW'(p + 1'b1);
    endfunction

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb begin
        usdp_state_t n;
        logic        fifo_en;
        logic        ir_mode;
        logic        line_in;
        logic        addr_ok;
        logic        alias_a;
        logic        alias_d;
        logic        data_ready;
        logic        rx_done;
        logic        rx_pop;
        logic        tx_load;
        logic        tx_push;
        logic        was_empty;
        logic        now_empty;
        logic [7:0]  rx_byte;
        logic [7:0]  tx_byte;
        logic [INT_W-1:0] ev;
        logic [INT_W-1:0] clr;
        n          = cur;
        fifo_en    = cur.ctrl[CTRL_FIFO_EN_BIT];
        ir_mode    = cur.ctrl[CTRL_IR_MODE_BIT];
        rx_done    = 1'b0;
        rx_pop     = 1'b0;
        tx_load    = 1'b0;
        tx_push    = 1'b0;
        rx_byte    = cur.rx_shift;
        tx_byte    = fifo_en ? cur.tx_mem[cur.tx_rd] : cur.transmit_holding;
        ev         = '0;
        clr        = '0;
        was_empty  = fifo_en ? (cur.tx_cnt == '0) : cur.tx_holding_empty_flag;
        data_ready = fifo_en ? (cur.rx_cnt != '0) : cur.rx_hold_valid;
        n.hreadyout = 1'b1;

        // -----------------------------------------------------------
        // input synchronisers
        // -----------------------------------------------------------
        n.sin_meta = sin;
        n.sin_sync = cur.sin_meta;
        n.sir_meta = sir_in;
        n.sir_sync = cur.sir_meta;
        line_in    = ir_mode ? cur.sir_sync : cur.sin_sync;

        // -----------------------------------------------------------
        // receiver, 8 data bits, one stop bit
        // -----------------------------------------------------------
        n.rx_timer = (cur.rx_timer != '0) ? TW'(cur.rx_timer - 1'b1) : '0;
        unique case (cur.rx_state)
            RX_IDLE: begin
                if (!line_in) begin
                    n.rx_state = RX_START;
                    n.rx_timer = TIME_HALF;
                end
            end
            RX_START: begin
                if (cur.rx_timer == '0) begin
                    // glitch shorter than half a bit is ignored
                    n.rx_state = line_in ? RX_IDLE : RX_DATA;
                    n.rx_timer = TIME_FULL;
                    n.rx_bit   = '0;
                end
            end
            RX_DATA: begin
                if (cur.rx_timer == '0) begin
                    n.rx_shift = {line_in, cur.rx_shift[7:1]};
                    n.rx_bit   = 3'(cur.rx_bit + 1'b1);
                    n.rx_timer = TIME_FULL;
                    if (cur.rx_bit == 3'h7) begin
                        n.rx_state = RX_STOP;
                    end
                end
            end
            RX_STOP: begin
                if (cur.rx_timer == '0) begin
                    // stop bit value not checked here
                    rx_done    = 1'b1;
                    n.rx_state = RX_IDLE;
                end
            end
        endcase

        // -----------------------------------------------------------
        // ahb address phase: decode and read
        // -----------------------------------------------------------
        addr_ok = hsel && hready && (htrans == HTRANS_NONSEQ || htrans[1]);
        alias_a = (haddr >= ALIAS_BASE) && (haddr <= ALIAS_LAST);
        n.req.pending = addr_ok;
        n.req.write   = hwrite;
        n.req.addr    = haddr;
        n.hrdata      = '0;
        if (addr_ok && !hwrite) begin
            if (alias_a) begin
                n.hrdata[7:0] = fifo_en ? cur.rx_mem[cur.rx_rd] : cur.rx_hold;
                rx_pop = data_ready;
            end else if (haddr == CTRL_ADDR) begin
                n.hrdata[CTRL_W-1:0] = cur.ctrl;
            end else if (haddr == LSR_ADDR) begin
                n.hrdata[LSR_DR_BIT]   = data_ready;
                n.hrdata[LSR_OE_BIT]   = cur.overrun;
                n.hrdata[LSR_TX_HOLDING_EMPTY_FLAG_BIT] = was_empty;
                // reading status clears the overrun flag
                n.overrun = 1'b0;
            end else if (haddr == INT_STAT_ADDR) begin
                n.hrdata[INT_W-1:0] = cur.int_stat;
            end else if (haddr == INT_MASK_ADDR) begin
                n.hrdata[INT_W-1:0] = cur.int_mask;
            end
        end

        // -----------------------------------------------------------
        // receive path storage
        // -----------------------------------------------------------
        if (rx_pop) begin
            if (fifo_en) begin
                n.rx_rd  = adv(cur.rx_rd);
                n.rx_cnt = CW'(n.rx_cnt - 1'b1);
            end else begin
                n.rx_hold_valid = 1'b0;
            end
        end
        if (rx_done) begin
            ev[INT_RX_BIT] = 1'b1;
            if (fifo_en) begin
                if (cur.rx_cnt == CNT_FULL && !rx_pop) begin
                    ev[INT_OE_BIT] = 1'b1;
                    ev[INT_RX_BIT] = 1'b0;
                end else begin
                    n.rx_mem[cur.rx_wr] = rx_byte;
                    n.rx_wr  = adv(cur.rx_wr);
                    n.rx_cnt = CW'(n.rx_cnt + 1'b1);
                end
            end else begin
                if (cur.rx_hold_valid && !rx_pop) begin
                    ev[INT_OE_BIT] = 1'b1;
                end
                n.rx_hold       = rx_byte;
                n.rx_hold_valid = 1'b1;
            end
        end
        if (ev[INT_OE_BIT]) begin
            n.overrun = 1'b1;
        end

        // -----------------------------------------------------------
        // transmitter, 8 data bits, one stop bit
        // -----------------------------------------------------------
        n.tx_timer = (cur.tx_timer != '0) ? TW'(cur.tx_timer - 1'b1) : '0;
        unique case (cur.tx_state)
            TX_IDLE: begin
                n.tx_line = 1'b1;
                if (!was_empty) begin
                    tx_load    = 1'b1;
                    n.tx_shift = tx_byte;
                    n.tx_line  = 1'b0;
                    n.tx_timer = TIME_FULL;
                    n.tx_state = TX_START;
                end
            end
            TX_START: begin
                if (cur.tx_timer == '0) begin
                    n.tx_line  = cur.tx_shift[0];
                    n.tx_bit   = '0;
                    n.tx_timer = TIME_FULL;
                    n.tx_state = TX_DATA;
                end
            end
            TX_DATA: begin
                if (cur.tx_timer == '0) begin
                    n.tx_shift = {1'b0, cur.tx_shift[7:1]};
                    n.tx_bit   = 3'(cur.tx_bit + 1'b1);
                    n.tx_timer = TIME_FULL;
                    n.tx_line  = cur.tx_shift[1];
                    if (cur.tx_bit == 3'h7) begin
                        n.tx_line  = 1'b1;
                        n.tx_state = TX_STOP;
                    end
                end
            end
            TX_STOP: begin
                if (cur.tx_timer == '0) begin
                    n.tx_state = TX_IDLE;
                end
            end
        endcase
        if (tx_load) begin
            if (fifo_en) begin
                n.tx_rd  = adv(cur.tx_rd);
                n.tx_cnt = CW'(n.tx_cnt - 1'b1);
            end else begin
                n.tx_holding_empty_flag = 1'b1;
            end
        end

        // -----------------------------------------------------------
        // ahb data phase: writes
        // -----------------------------------------------------------
        alias_d = (cur.req.addr >= ALIAS_BASE) && (cur.req.addr <= ALIAS_LAST);
        if (cur.req.pending && cur.req.write) begin
            if (alias_d) begin
                tx_push = 1'b1;
            end else if (cur.req.addr == INT_STAT_ADDR) begin
                clr = hwdata[INT_W-1:0];
            end else if (cur.req.addr == INT_MASK_ADDR) begin
                n.int_mask = hwdata[INT_W-1:0];
            end
        end
        if (tx_push) begin
            if (fifo_en) begin
                if (cur.tx_cnt != CNT_FULL || tx_load) begin
                    n.tx_mem[cur.tx_wr] = hwdata[7:0];
                    n.tx_wr  = adv(cur.tx_wr);
                    n.tx_cnt = CW'(n.tx_cnt + 1'b1);
                end
            end else begin
                n.transmit_holding  = hwdata[7:0];
                n.tx_holding_empty_flag = 1'b0;
            end
        end

        // a change of fifo enable flushes both paths so no stale byte survives
        if (cur.req.pending && cur.req.write && cur.req.addr == CTRL_ADDR) begin
            n.ctrl = hwdata[CTRL_W-1:0];
            if (hwdata[CTRL_FIFO_EN_BIT] != fifo_en) begin
                n.rx_rd         = '0;
                n.rx_wr         = '0;
                n.rx_cnt        = '0;
                n.tx_rd         = '0;
                n.tx_wr         = '0;
                n.tx_cnt        = '0;
                n.rx_hold_valid = 1'b0;
                n.tx_holding_empty_flag          = 1'b1;
            end
        end

        // -----------------------------------------------------------
        // interrupt status, set wins over clear
        // -----------------------------------------------------------
        now_empty = n.ctrl[CTRL_FIFO_EN_BIT] ? (n.tx_cnt == '0) : n.tx_holding_empty_flag;
        ev[INT_TX_HOLDING_EMPTY_FLAG_BIT] = !was_empty && now_empty;
        n.int_stat = (cur.int_stat & ~clr) | ev;
        n.irq      = |(n.int_stat & n.int_mask);

        // -----------------------------------------------------------
        // line outputs
        // -----------------------------------------------------------
        n.sout      = n.ctrl[CTRL_IR_MODE_BIT] ? 1'b1 : n.tx_line;
        n.sir_out_n = n.ctrl[CTRL_IR_MODE_BIT] ? n.tx_line : 1'b1;
        next_cur    = n;
    end

    // ---------------------------------------------------------------
    // state register
    // ---------------------------------------------------------------
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            cur               <= '0;
            cur.hreadyout     <= 1'b1;
            cur.ctrl          <= CTRL_RESET;
            cur.int_stat      <= INT_STAT_RESET;
            cur.int_mask      <= INT_MASK_RESET;
            cur.tx_holding_empty_flag          <= 1'b1;
            cur.sin_meta      <= 1'b1;
            cur.sin_sync      <= 1'b1;
            cur.sir_meta      <= 1'b1;
            cur.sir_sync      <= 1'b1;
            cur.rx_state      <= RX_IDLE;
            cur.tx_state      <= TX_IDLE;
            cur.tx_line       <= 1'b1;
            cur.sout          <= 1'b1;
            cur.sir_out_n     <= 1'b1;
        end else begin
            cur <= next_cur;
        end
    end

    // bus answer is always okay
    assign hrdata    = cur.hrdata;
    assign hreadyout = cur.hreadyout;
    assign hresp     = 1'b0;
    assign irq       = cur.irq;
    assign sout      = cur.sout;
    assign sir_out_n = cur.sir_out_n;

endmodule // usdp_top

//--- dv/usdp_chk.sv
// assertion checker of the shadow data port
`timescale 1ns/1ps
module usdp_chk
    import usdp_pkg::*;
(
    input wire logic        clk_sys,
    input wire logic        srst,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic        irq,
    input wire logic        sout,
    input wire logic        sir_out_n
);
    logic take, hit, mapped, rd_q, rda_q, rdu_q, wc_q, ir_q, ir_qq;
    assign take = hsel & hreadyout & htrans[1];
    assign hit = haddr >= ALIAS_BASE && haddr <= ALIAS_LAST;
    assign mapped = hit || haddr == CTRL_ADDR || haddr == LSR_ADDR ||
        haddr == INT_STAT_ADDR || haddr == INT_MASK_ADDR;
    // ---------------------------------------------
    // bus shadow, ir mode lands with the write
    // ---------------------------------------------
    always_ff @(posedge clk_sys) begin
        rd_q <= take & !hwrite;
        rda_q <= take & !hwrite & hit;
        rdu_q <= take & !hwrite & !mapped;
        wc_q <= take & hwrite & (haddr == CTRL_ADDR);
        ir_qq <= ir_q;
        if (srst)
            ir_q <= 1'b0;
        else if (wc_q)
            ir_q <= hwdata[CTRL_IR_MODE_BIT];
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    a_resp_okay: assert property (hresp == 1'b0)
        else $error("response not okay");
    a_zero_wait: assert property (!$past(srst) |-> hreadyout)
        else $error("wait state inserted");
    a_alias_upper: assert property (rda_q |-> hrdata[31:8] == 24'h0)
        else $error("alias upper bits not zero");
    a_unmap_zero: assert property (rdu_q |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    a_idle_rdata: assert property (!rd_q |-> hrdata == 32'h0)
        else $error("read data outside a read");
    a_ir_sout: assert property (ir_q && ir_qq |-> sout)
        else $error("serial output active in ir mode");
    a_uart_sir: assert property (!ir_q && !ir_qq |-> sir_out_n)
        else $error("ir output active in serial mode");
    a_reset_idle: assert property (
        $fell(srst) |-> sout && sir_out_n && !irq)
        else $error("outputs not idle after reset");
    c_alias_rd: cover property (rda_q && hrdata[7:0] != 8'h00);
    c_irq: cover property ($rose(irq));
    c_uart_tx: cover property ($fell(sout));
    c_ir_tx: cover property ($fell(sir_out_n));
endmodule // usdp_chk

//--- dv/usdp_remote.sv
// serial and infrared far end of the shadow data port
`timescale 1ns/1ps
module usdp_remote #(
    parameter int BIT_CYCLES = 8
) (
    input  wire logic clk_sys,
    output logic      sin,
    output logic      sir_in,
    input  wire logic sout,
    input  wire logic sir_out_n
);
    logic [7:0] rxq[$];
    logic [7:0] b;
    wire        rx_line = sout & sir_out_n;
    initial begin
        sin = 1'b1;
        sir_in = 1'b1;
    end
    task automatic send(input logic [7:0] d, input logic ir);
        logic [9:0] f;
        f = {1'b1, d, 1'b0};
        for (int i = 0; i < 10; i++) begin
            if (ir)
                sir_in <= f[i];
            else
                sin <= f[i];
            repeat (BIT_CYCLES) @(posedge clk_sys);
        end
    endtask
    // the idle one of the two outputs stays high, so and them
    always begin
        @(negedge rx_line);
        repeat (BIT_CYCLES / 2) @(posedge clk_sys);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CYCLES) @(posedge clk_sys);
            b[i] = rx_line;
        end
        // stop at the start of the stop bit, a back-to-back start follows soon after
        repeat (BIT_CYCLES / 2) @(posedge clk_sys);
        rxq.push_back(b);
    end
endmodule // usdp_remote

//--- dv/usdp_top_tb_top.sv
// self-checking bench of the shadow data port
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin \
    num_errors++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, (a), (e)); end end
module usdp_top_tb_top
    import usdp_pkg::*;
;
    localparam int DEPTH = 4;
    localparam int BITC  = 8;
    logic        clk_sys = 1'b0, srst = 1'b1, hsel = 1'b1, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2;
    logic        hready, hreadyout, hresp, irq, sin, sir_in, sout, sir_out_n;
    int          num_errors = 0, checks_done = 0;
    always #5 clk_sys = ~clk_sys;
    assign hready = hreadyout;
    usdp_top #(.DEPTH(DEPTH), .BIT_CYCLES(BITC)) i_usdp_top (
        .clk_sys, .srst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
        .hready, .hrdata, .hreadyout, .hresp, .irq, .sin, .sir_in, .sout,
        .sir_out_n
    );
    usdp_remote #(.BIT_CYCLES(BITC)) i_usdp_remote (
        .clk_sys, .sin, .sir_in, .sout, .sir_out_n
    );
    // ---------------------------------------------
    // bus tasks
    // ---------------------------------------------
    task automatic finish_test();
        if (num_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic fail_out();
        num_errors++;
        finish_test();
    endtask
    task automatic edge_rdy();
        for (int n = 0; n == 0 || hready !== 1'b1; n++) begin
            if (n == 64)
                fail_out();
            @(posedge clk_sys);
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, d);
        hwrite <= w;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        edge_rdy();
        htrans <= 2'h0;
        hwdata <= d;
        edge_rdy();
        rd = hrdata;
    endtask
    task automatic rd_chk(input logic [31:0] a, e);
        xfer(1'b0, a, 32'h0);
        `CHK(rd, e)
    endtask
    task automatic wr(input logic [31:0] a, d);
        xfer(1'b1, a, d);
    endtask
    task automatic wait_dr();
        rd = 32'h0;
        for (int n = 0; rd[LSR_DR_BIT] !== 1'b1; n++) begin
            if (n == 200)
                fail_out();
            xfer(1'b0, LSR_ADDR, 32'h0);
        end
    endtask
    task automatic wait_rxq(input int k);
        for (int n = 0; i_usdp_remote.rxq.size() < k; n++) begin
            if (n == 4000)
                fail_out();
            @(posedge clk_sys);
        end
    endtask
    initial begin
        logic [7:0] b;
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        @(posedge clk_sys);
        rd_chk(LSR_ADDR, 32'h20);
        rd_chk(ALIAS_BASE - 32'h4, 32'h0);
        wr(INT_MASK_ADDR, 32'h1);
        for (int k = 0; k < ALIAS_WORDS; k++) begin
            b = {k[3:0], ~k[3:0]};
            i_usdp_remote.send(b, 1'b0);
            wait_dr();
            `CHK(irq, 1'b1)
            wr(INT_STAT_ADDR, 32'h7);
            rd_chk(ALIAS_BASE + 4 * k, {24'h0, b});
            `CHK(irq, 1'b0)
            rd_chk(LSR_ADDR, 32'h20);
        end
        // masked event, overrun without fifos
        wr(INT_MASK_ADDR, 32'h0);
        i_usdp_remote.send(8'h11, 1'b0);
        i_usdp_remote.send(8'h22, 1'b0);
        rd_chk(LSR_ADDR, 32'h23);
        `CHK(irq, 1'b0)
        rd_chk(INT_STAT_ADDR, 32'h3);
        rd_chk(ALIAS_BASE, 32'h22);
        rd_chk(LSR_ADDR, 32'h20);
        // holding byte overwritten while the shifter is busy
        rd_chk(LSR_ADDR, 32'h20);
        wr(ALIAS_BASE, 32'h3C);
        wr(ALIAS_BASE + 32'h4, 32'h5A);
        rd_chk(LSR_ADDR, 32'h0);
        wr(ALIAS_LAST, 32'h77);
        wait_rxq(2);
        `CHK(i_usdp_remote.rxq[0], 8'h3C)
        `CHK(i_usdp_remote.rxq[1], 8'h77)
        // infrared both ways
        wr(CTRL_ADDR, 32'h2);
        i_usdp_remote.rxq.delete();
        wr(ALIAS_BASE + 32'h8, 32'h96);
        i_usdp_remote.send(8'h69, 1'b1);
        wait_dr();
        rd_chk(ALIAS_BASE + 32'h8, 32'h69);
        wait_rxq(1);
        `CHK(i_usdp_remote.rxq[0], 8'h96)
        // fifo mode, full receive and transmit fifos
        wr(CTRL_ADDR, 32'h1);
        for (int k = 0; k <= DEPTH; k++)
            i_usdp_remote.send(8'h40 + k[7:0], 1'b0);
        rd_chk(LSR_ADDR, 32'h23);
        for (int k = 0; k < DEPTH; k++)
            rd_chk(ALIAS_BASE + 32'h10, 32'h40 + k);
        rd_chk(LSR_ADDR, 32'h20);
        i_usdp_remote.rxq.delete();
        for (int k = 0; k < DEPTH + 3; k++)
            wr(ALIAS_LAST, 32'hA0 + k);
        wait_rxq(DEPTH + 1);
        // two frame times, long enough for a stray extra byte
        repeat (BITC * 20) @(posedge clk_sys);
        `CHK(i_usdp_remote.rxq.size(), DEPTH + 1)
        for (int k = 0; k <= DEPTH; k++)
            `CHK(i_usdp_remote.rxq[k], 8'hA0 + k[7:0])
        finish_test();
    end
endmodule // usdp_top_tb_top
bind usdp_top usdp_chk i_usdp_chk (
    .clk_sys, .srst, .hsel, .haddr, .htrans, .hwrite, .hwdata, .hrdata,
    .hreadyout, .hresp, .irq, .sout, .sir_out_n
);
